//--- dcb_defs.vh
// Constants for the coefficient double-buffer filter block
`ifndef DCB_DEFS_VH
`define DCB_DEFS_VH

// Register pages: bank A on 8/9, bank B on 12/13
`define DCB_PG_A_LO 8'h08
`define DCB_PG_A_HI 8'h09
`define DCB_PG_B_LO 8'h0c
`define DCB_PG_B_HI 8'h0d

// Register addresses inside a page
`define DCB_CTRL_REG 7'h01
`define DCB_COEF_FIRST 7'h02
`define DCB_BQ_LAST 7'h7d
`define DCB_IIR_LAST 7'h0d

// Coefficient layout
`define DCB_COEF_BASE 2
`define DCB_BQ_STRIDE 10
`define DCB_BQ_CH_STRIDE 64
`define DCB_IIR_CH_STRIDE 6
`define DCB_NUM_BQ 6

// Adaptive control register fields
`define DCB_BIT_SWAP 0
`define DCB_BIT_BANK 1
`define DCB_BIT_DBUF 2
`define DCB_CTRL_RST 8'h00

// Coefficient range and reset values, 1.15 format
`define DCB_COEF_MAX 16'h7fff
`define DCB_COEF_MIN 16'h8000
`define DCB_NUM0_RST `DCB_COEF_MAX
`define DCB_COEF_RST 16'h0000
`define DCB_FRAC_BITS 15
`define DCB_MAX_BQ 3'h6

`endif

//--- dcb_ctrl.v
// Adaptive control register: double-buffer enable, swap request, bank flag
`timescale 1ns/10ps
`include "dcb_defs.vh"

module dcb_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Register write and state
  input wire ctrl_wr_i,
  input wire [7:0] ctrl_wdata_i,
  input wire running_i,
  input wire sample_start_i,
  // Control outputs
  output wire dbuf_en_o,
  output wire swap_pend_o,
  output wire bank_sel_o,
  output wire [7:0] ctrl_rdata_o
);

  localparam [7:0] CTRL_RST = `DCB_CTRL_RST;

  reg dbuf_r;
  reg swap_r;
  reg bank_r;
  wire swap_now;
  wire swap_set;

  // Swap only while running with double-buffering on, at a sample start
  assign swap_now = swap_r & running_i & dbuf_r & sample_start_i;
  assign swap_set = ctrl_wr_i & ctrl_wdata_i[`DCB_BIT_SWAP] &
                    running_i & ctrl_wdata_i[`DCB_BIT_DBUF];

  // A new request in the swap cycle wins over the self-clear
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      dbuf_r <= CTRL_RST[`DCB_BIT_DBUF];
      swap_r <= CTRL_RST[`DCB_BIT_SWAP];
      bank_r <= CTRL_RST[`DCB_BIT_BANK];
    end else begin
      if (ctrl_wr_i)
        dbuf_r <= ctrl_wdata_i[`DCB_BIT_DBUF];
      if (swap_set)
        swap_r <= 1'b1;
      else if (swap_now)
        swap_r <= 1'b0;
      else if (!running_i || !dbuf_r)
        swap_r <= 1'b0;
      if (swap_now)
        bank_r <= ~bank_r;
    end
  end

  assign dbuf_en_o = dbuf_r;
  assign swap_pend_o = swap_r;
  assign bank_sel_o = bank_r;
  assign ctrl_rdata_o = {5'h00, dbuf_r, bank_r, swap_r};

endmodule

//--- dcb_section.v
// One filter section: biquad or first-order IIR, 1.15 coefficients
`timescale 1ns/10ps
`include "dcb_defs.vh"

module dcb_section (
  // Mode
  input wire iir_mode_i,
  // Samples and history
  input wire [15:0] x_i,
  input wire [15:0] x1_i,
  input wire [15:0] x2_i,
  input wire [15:0] y1_i,
  input wire [15:0] y2_i,
  // Coefficients
  input wire [15:0] n0_i,
  input wire [15:0] n1_i,
  input wire [15:0] n2_i,
  input wire [15:0] d1_i,
  input wire [15:0] d2_i,
  // Result
  output wire [15:0] y_o
);

  wire signed [31:0] p0 = $signed(n0_i) * $signed(x_i);
  wire signed [31:0] p1 = $signed(n1_i) * $signed(x1_i);
  wire signed [31:0] p2 = $signed(n2_i) * $signed(x2_i);
  wire signed [31:0] p3 = $signed(d1_i) * $signed(y1_i);
  wire signed [31:0] p4 = $signed(d2_i) * $signed(y2_i);
  wire signed [39:0] e0 = {{8{p0[31]}}, p0};
  wire signed [39:0] e1 = {{8{p1[31]}}, p1};
  wire signed [39:0] e2 = {{8{p2[31]}}, p2};
  wire signed [39:0] e3 = {{8{p3[31]}}, p3};
  wire signed [39:0] e4 = {{8{p4[31]}}, p4};

  // Biquad doubles the first-order terms; the IIR keeps them single
  wire signed [39:0] e1s = iir_mode_i ? e1 : (e1 <<< 1);
  wire signed [39:0] e3s = iir_mode_i ? e3 : (e3 <<< 1);
  wire signed [39:0] acc = e0 + e1s + e2 + e3s + e4;

  // Dividing by 2^15 is the shift; saturate instead of wrapping
  wire signed [39:0] q = acc >>> `DCB_FRAC_BITS;
  wire ovf = ~((&q[39:15]) | ~(|q[39:15]));

  assign y_o = ovf ? (q[39] ? `DCB_COEF_MIN : `DCB_COEF_MAX) : q[15:0];

endmodule

//--- dcb_filter_top.v
// Playback filter stage with double-buffered coefficient banks
//
// Operation
// - Zero to six cascaded biquads per channel.
// - Coefficients indexed sequentially in banks A, B.
// - Running without double-buffering locks coefficient access.
// - Control bit two enables double buffering.
// - Bit zero swaps banks next sample, self-clears.
// - Bit one shows bank in use, toggles.
// - Running: writes go to the idle bank.
// - Powered down: writes go to addressed bank.
// - Bank A pages 8/9, bank B 12/13.
// - Coefficient is 16 bits over two bytes.
// - Coefficients are signed 1.15 fractions.
// - First-order IIR transfer function with 2^15 denominator.
// - IIR coefficients on page 9, flat reset.
// - Biquad transfer function with doubled first-order terms.
// - Left biquads page 8 registers 2 to 61.
// - Right biquads page 8 registers 66 to 125.
// - Running follows left and right power bits.
`timescale 1ns/10ps
`include "dcb_defs.vh"

module dcb_filter_top (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Decoded control-bus register access, one byte per access
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_page_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  output wire reg_rvalid_o,
  // DAC power bits and processing block choice
  input wire dac_left_pwr_i,
  input wire dac_right_pwr_i,
  input wire [2:0] bq_count_i,
  input wire iir_en_i,
  // Sample stream
  input wire sample_start_i,
  input wire [15:0] smp_left_i,
  input wire [15:0] smp_right_i,
  output wire [15:0] out_left_o,
  output wire [15:0] out_right_o,
  output wire out_valid_o
);

  // Engine states
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam [15:0] NUM0_RST = `DCB_NUM0_RST;
  localparam [15:0] COEF_RST = `DCB_COEF_RST;

  integer i;

  // Two banks of two pages of 128 bytes: index {bank, upper page, reg}
  reg [7:0] coef_mem [0:511];
  reg [7:0] rdata_r;
  reg rvalid_r;
  reg st_r;
  reg [2:0] stage_r;
  reg valid_r;

  wire running;
  wire dbuf_en;
  wire bank_sel;
  wire [7:0] ctrl_rdata;
  wire pg_a;
  wire pg_b;
  wire pg_hi;
  wire coef_hit;
  wire ctrl_hit;
  wire locked;
  wire coef_we;
  wire coef_open;
  wire host_bank;
  wire [8:0] host_idx;
  wire [2:0] nbq;
  wire [2:0] first_stage;
  wire start;
  wire bypass;
  wire last;
  wire [15:0] sec_y [0:1];

  // Reset byte for a coefficient location: numerator0 is 1 - LSB
  function [7:0] rst_byte;
    input [8:0] idx;
    integer a;
    integer r;
    begin
      a = idx[6:0];
      rst_byte = COEF_RST[7:0];
      if (!idx[7]) begin
        if (a >= `DCB_COEF_BASE + `DCB_BQ_CH_STRIDE)
          r = a - `DCB_COEF_BASE - `DCB_BQ_CH_STRIDE;
        else
          r = a - `DCB_COEF_BASE;
        if (r >= 0 && r < `DCB_NUM_BQ * `DCB_BQ_STRIDE) begin
          if ((r % `DCB_BQ_STRIDE) == 0)
            rst_byte = NUM0_RST[15:8];
          else if ((r % `DCB_BQ_STRIDE) == 1)
            rst_byte = NUM0_RST[7:0];
        end
      end else begin
        r = a - `DCB_COEF_BASE;
        if (r >= 0 && r < 2 * `DCB_IIR_CH_STRIDE) begin
          if ((r % `DCB_IIR_CH_STRIDE) == 0)
            rst_byte = NUM0_RST[15:8];
          else if ((r % `DCB_IIR_CH_STRIDE) == 1)
            rst_byte = NUM0_RST[7:0];
        end
      end
    end
  endfunction

  // Byte index of the MSB of coefficient k of a section
  function [8:0] cidx;
    input bank;
    input ch;
    input [2:0] stage;
    input [2:0] k;
    integer a;
    begin
      if (stage == 3'h0)
        a = `DCB_COEF_BASE + ch * `DCB_IIR_CH_STRIDE + 2 * k;
      else
        a = `DCB_COEF_BASE + ch * `DCB_BQ_CH_STRIDE +
            (stage - 1) * `DCB_BQ_STRIDE + 2 * k;
      cidx = {bank, (stage == 3'h0), a[6:0]};
    end
  endfunction

  // Either channel powered counts as the DAC running
  assign running = dac_left_pwr_i | dac_right_pwr_i;

  // Page and register decode
  assign pg_a = (reg_page_i == `DCB_PG_A_LO) |
                (reg_page_i == `DCB_PG_A_HI);
  assign pg_b = (reg_page_i == `DCB_PG_B_LO) |
                (reg_page_i == `DCB_PG_B_HI);
  assign pg_hi = (reg_page_i == `DCB_PG_A_HI) |
                 (reg_page_i == `DCB_PG_B_HI);
  assign coef_hit = (pg_a | pg_b) & (reg_addr_i >= `DCB_COEF_FIRST) &
                    (pg_hi ? (reg_addr_i <= `DCB_IIR_LAST) :
                             (reg_addr_i <= `DCB_BQ_LAST));
  // Page 12 register 1 is not a second control register
  assign ctrl_hit = (reg_page_i == `DCB_PG_A_LO) &
                    (reg_addr_i == `DCB_CTRL_REG);

  // Coefficients are untouchable while running single-buffered
  assign locked = running & ~dbuf_en;

  // Host access to a coefficient byte; locked ones are neither written
  // nor shown, and the host gets no sign that it was refused
  assign coef_open = coef_hit & ~locked;
  assign coef_we = reg_wr_i & coef_open;

  // Running: the idle bank, whatever was addressed; else the addressed one
  // Reads follow the same path, so the host sees what it wrote
  assign host_bank = running ? ~bank_sel : pg_b;
  assign host_idx = {host_bank, pg_hi, reg_addr_i};

  // Coefficient store; reset loads the flat-response defaults
  // Reset rewrites all bytes in one cycle: wide, but needs no counter
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (i = 0; i < 512; i = i + 1)
        coef_mem[i] <= rst_byte(i[8:0]);
    end else if (coef_we) begin
      coef_mem[host_idx] <= reg_wdata_i;
    end
  end

  // Read path: locked and unmapped locations read as zero
  // Read data holds until the next read, so a slow host may take it late
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i) begin
        if (ctrl_hit)
          rdata_r <= ctrl_rdata;
        else if (coef_open)
          rdata_r <= coef_mem[host_idx];
        else
          rdata_r <= 8'h00;
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // Adaptive control register and bank flag
  // The pending swap stays internal; the host sees it in the read-back
  dcb_ctrl u_ctrl (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ctrl_wr_i(reg_wr_i & ctrl_hit),
    .ctrl_wdata_i(reg_wdata_i),
    .running_i(running),
    .sample_start_i(sample_start_i),
    .dbuf_en_o(dbuf_en),
    .swap_pend_o(),
    .bank_sel_o(bank_sel),
    .ctrl_rdata_o(ctrl_rdata)
  );

  // Section count from the processing block, clamped to six
  // A count of seven is no valid chain, so it runs as six
  assign nbq = (bq_count_i > `DCB_MAX_BQ) ? `DCB_MAX_BQ : bq_count_i;
  assign start = (st_r == ST_IDLE) & sample_start_i;
  assign bypass = ~iir_en_i & (nbq == 3'h0);
  // Chain opens at the IIR when present, else at biquad A
  assign first_stage = iir_en_i ? 3'h0 : 3'h1;
  assign last = (stage_r >= nbq);

  // Sequencer: one section per cycle, IIR first, then biquads A to F.
  // A sample start during a pass is dropped; a pass takes at most 7 cycles.
  // A smaller chain asked for mid-pass ends it early, as last uses >=.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= ST_IDLE;
      stage_r <= 3'h0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (start) begin
            if (bypass) begin
              valid_r <= 1'b1;
            end else begin
              st_r <= ST_RUN;
              stage_r <= first_stage;
            end
          end
        end
        ST_RUN: begin
          if (last) begin
            st_r <= ST_IDLE;
            valid_r <= 1'b1;
          end else begin
            stage_r <= stage_r + 3'h1;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Per-channel datapath: history per section, coefficients from in-use bank
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chn
      integer j;
      reg [15:0] x_r;
      reg [15:0] y_r;
      reg [15:0] sx1 [0:6];
      reg [15:0] sx2 [0:6];
      reg [15:0] sy1 [0:6];
      reg [15:0] sy2 [0:6];
      wire is_iir = (stage_r == 3'h0);
      wire [15:0] din = (g == 0) ? smp_left_i : smp_right_i;
      wire ch = (g == 1);
      // Byte index of each coefficient's high byte, bank in use
      wire [8:0] i0 = cidx(bank_sel, ch, stage_r, 3'h0);
      wire [8:0] i1 = cidx(bank_sel, ch, stage_r, 3'h1);
      wire [8:0] i2 = cidx(bank_sel, ch, stage_r, 3'h2);
      wire [8:0] i3 = cidx(bank_sel, ch, stage_r, 3'h3);
      wire [8:0] i4 = cidx(bank_sel, ch, stage_r, 3'h4);
      // Plain array reads, so a host write to the bank in use reaches the engine at once;
      // the low byte sits at the odd register after the high one
      wire [15:0] c0 = {coef_mem[i0], coef_mem[i0 + 9'h001]};
      wire [15:0] c1 = {coef_mem[i1], coef_mem[i1 + 9'h001]};
      wire [15:0] c2 = {coef_mem[i2], coef_mem[i2 + 9'h001]};
      wire [15:0] c3 = {coef_mem[i3], coef_mem[i3 + 9'h001]};
      wire [15:0] c4 = {coef_mem[i4], coef_mem[i4 + 9'h001]};
      // IIR slots are numerator0, numerator1, denominator1; others zero
      wire [15:0] n2_sel = is_iir ? COEF_RST : c2;
      wire [15:0] d1_sel = is_iir ? c2 : c3;
      wire [15:0] d2_sel = is_iir ? COEF_RST : c4;

      // One shared section per channel, stepped through the cascade
      dcb_section u_sec (
        .iir_mode_i(is_iir),
        .x_i(x_r),
        .x1_i(sx1[stage_r]),
        .x2_i(sx2[stage_r]),
        .y1_i(sy1[stage_r]),
        .y2_i(sy2[stage_r]),
        .n0_i(c0),
        .n1_i(c1),
        .n2_i(n2_sel),
        .d1_i(d1_sel),
        .d2_i(d2_sel),
        .y_o(sec_y[g])
      );

      // Output of one section feeds the next one in the cascade
      // History is cleared by reset only; a changed chain reuses old state
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          x_r <= 16'h0000;
          y_r <= 16'h0000;
          for (j = 0; j < 7; j = j + 1) begin
            sx1[j] <= 16'h0000;
            sx2[j] <= 16'h0000;
            sy1[j] <= 16'h0000;
            sy2[j] <= 16'h0000;
          end
        end else begin
          if (start && bypass)
            y_r <= din;
          else if (start)
            x_r <= din;
          if (st_r == ST_RUN) begin
            x_r <= sec_y[g];
            sx1[stage_r] <= x_r;
            sx2[stage_r] <= sx1[stage_r];
            sy1[stage_r] <= sec_y[g];
            sy2[stage_r] <= sy1[stage_r];
            if (last)
              y_r <= sec_y[g];
          end
        end
      end
    end
  endgenerate

  assign out_left_o = chn[0].y_r;
  assign out_right_o = chn[1].y_r;
  assign out_valid_o = valid_r;

endmodule

//--- dcb_filter_top_props.sv
// Assertions on the filter block's register and sample ports
`timescale 1ns/10ps
module dcb_filter_top_props (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Register access
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_page_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  // Power and stream
  input wire dac_left_pwr_i,
  input wire dac_right_pwr_i,
  input wire sample_start_i,
  input wire out_valid_o
);
  // Shadow of the buffering enable, to tell when reads are locked
  reg dbuf_r;
  always @(posedge clk_i) begin
    if (sys_rst_i)
      dbuf_r <= 1'b0;
    else if (reg_wr_i && reg_page_i == 8'h08 && reg_addr_i == 7'h01)
      dbuf_r <= reg_wdata_i[2];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rd_ans;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read gave no valid");
  property p_rv_pulse;
    !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rv_pulse: assert property (p_rv_pulse)
    else $error("valid without read");
  property p_rd_hold;
    !reg_rvalid_o |-> $stable(reg_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  // Running without buffering hides every coefficient on page 8
  property p_lock;
    reg_rd_i && (dac_left_pwr_i || dac_right_pwr_i) && !dbuf_r &&
      reg_page_i == 8'h08 && reg_addr_i > 7'h01 |=> reg_rdata_o == 8'h00;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked read gave data");
  property p_no_page;
    reg_rd_i && reg_page_i == 8'h0a |=> reg_rdata_o == 8'h00;
  endproperty
  a_no_page: assert property (p_no_page)
    else $error("unmapped page gave data");
  property p_bq_end;
    reg_rd_i && reg_page_i == 8'h08 && reg_addr_i > 7'h7d |=>
      reg_rdata_o == 8'h00;
  endproperty
  a_bq_end: assert property (p_bq_end)
    else $error("read past last biquad gave data");
  property p_iir_end;
    reg_rd_i && reg_page_i == 8'h09 && reg_addr_i > 7'h0d |=>
      reg_rdata_o == 8'h00;
  endproperty
  a_iir_end: assert property (p_iir_end)
    else $error("read past last section gave data");
  property p_lat;
    sample_start_i |-> ##[1:9] out_valid_o;
  endproperty
  a_lat: assert property (p_lat)
    else $error("no output after sample start");
  c_dbuf_rd: cover property (reg_rd_i && dbuf_r);
  c_fast: cover property (sample_start_i ##1 out_valid_o);
  c_wr_b: cover property (reg_wr_i && reg_page_i == 8'h0c);
endmodule

//--- dcb_host.sv
// Host model driving byte accesses on the register port
`timescale 1ns/10ps
module dcb_host (
  // Clock
  input wire clk_i,
  // Register port towards the block
  output reg reg_wr_o,
  output reg reg_rd_o,
  output reg [7:0] reg_page_o,
  output reg [6:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  input wire [7:0] reg_rdata_i,
  input wire reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_page_o = 8'h00;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end
  // Idle lines show the inverse, so stale values never pass
  task drop;
    begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_page_o = ~reg_page_o;
      reg_addr_o = ~reg_addr_o;
      reg_wdata_o = ~reg_wdata_o;
    end
  endtask
  // Byte write; a spare edge keeps a strobe from toggling twice at once
  task wr(input integer p, input integer a, input integer d);
    begin
      reg_page_o = p[7:0];
      reg_addr_o = a[6:0];
      reg_wdata_o = d[7:0];
      reg_wr_o = 1'b1;
      @(posedge clk_i);
      #2 drop;
      @(posedge clk_i);
      #2;
    end
  endtask
  // Byte read; data is taken in the cycle that valid stands
  task rd(input integer p, input integer a, output [7:0] d);
    begin
      reg_page_o = p[7:0];
      reg_addr_o = a[6:0];
      reg_rd_o = 1'b1;
      @(posedge clk_i);
      #2 drop;
      d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
      @(posedge clk_i);
      #2;
    end
  endtask
  // Coefficient write, high byte to the lower register
  task wr16(input integer p, input integer a, input [15:0] v);
    begin
      wr(p, a, v[15:8]);
      wr(p, a + 1, v[7:0]);
    end
  endtask
endmodule

//--- test_dac_coefficient_double_buffer.sv
// Self-checking bench for the coefficient double-buffer filter block
`timescale 1ns/10ps
module test_dac_coefficient_double_buffer;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  wire reg_wr_i, reg_rd_i, reg_rvalid_o, out_valid_o;
  wire [7:0] reg_page_i, reg_wdata_i, reg_rdata_o;
  wire [6:0] reg_addr_i;
  wire [15:0] out_left_o, out_right_o;
  reg dac_left_pwr_i = 1'b0;
  reg dac_right_pwr_i = 1'b0;
  reg iir_en_i = 1'b0;
  reg sample_start_i = 1'b0;
  reg [2:0] bq_count_i = 3'h0;
  reg [15:0] smp_left_i = 16'h0000;
  reg [15:0] smp_right_i = 16'h0000;
  integer fails = 0;
  integer n_tests = 0;
  integer seed = 66589;
  integer mem [integer];
  integer i, pg, a, v;
  reg [7:0] d;
  always #25 clk_i = ~clk_i;
  dcb_filter_top dcb_filter_top_inst (.*);
  dcb_host dcb_host_inst (.clk_i(clk_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_page_o(reg_page_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));
  task end_sim;
    begin
      if (fails == 0 && n_tests > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Model key: bank, odd page, address
  function integer mk(input integer p, input integer a, input integer b);
    mk = b * 1000 + (p % 2) * 200 + a;
  endfunction
  // Flat reset: numerator0 is 0x7fff, high byte first
  function integer rstv(input integer p, input integer a);
    integer q;
    begin
      q = (p % 2) ? (a - 2) % 6 : (a < 64 ? a - 2 : a - 66) % 10;
      rstv = q == 0 ? 8'h7f : q == 1 ? 8'hff : 0;
    end
  endfunction
  task rdc(input integer p, input integer a, input integer b);
    begin
      dcb_host_inst.rd(p, a, d);
      chk(d, mem.exists(mk(p, a, b)) ? mem[mk(p, a, b)] : rstv(p, a));
    end
  endtask
  task rdz(input integer p, input integer a);
    begin
      dcb_host_inst.rd(p, a, d);
      chk(d, 16'h0000);
    end
  endtask
  task wrm(input integer p, input integer a, input integer x,
    input integer b);
    begin
      dcb_host_inst.wr(p, a, x);
      mem[mk(p, a, b)] = x & 255;
    end
  endtask
  // One sample pass; history stays silent since only numerator0 is set
  task st(input integer bq, input integer iir);
    integer n, c, x, y, z;
    begin
      n = iir + (bq > 6 ? 6 : bq);
      bq_count_i = bq[2:0];
      iir_en_i = iir[0];
      x = $random(seed) % 32768;
      smp_left_i = x[15:0];
      smp_right_i = -x;
      sample_start_i = 1'b1;
      @(posedge clk_i);
      #2 sample_start_i = 1'b0;
      // Valid stands in the cycle after the edge that raised it
      c = 1;
      while (out_valid_o !== 1'b1 && c < 20) begin
        @(posedge clk_i);
        #2 c = c + 1;
      end
      y = x;
      z = -x;
      repeat (n) begin
        y = (32767 * y) >>> 15;
        z = (32767 * z) >>> 15;
      end
      chk(c, n + 1);
      chk(out_left_o, y[15:0]);
      chk(out_right_o, z[15:0]);
      if (out_valid_o !== 1'b1)
        end_sim;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    #2 sys_rst_i = 1'b0;
    // Reset contents of both banks, random places
    for (i = 0; i < 16; i = i + 1) begin
      pg = 8 + (i % 2) + (i / 8) * 4;
      a = 2 + {$random(seed)} % (pg % 2 ? 12 : 124);
      if (a > 61 && a < 66)
        a = a + 4;
      rdc(pg, a, pg / 12);
    end
    rdz(10, 2);
    rdz(8, 126);
    rdz(9, 14);
    rdz(12, 1);
    dcb_host_inst.rd(8, 1, d);
    chk(d, 16'h0000);
    for (i = 0; i < 4; i = i + 1)
      st(i < 2 ? i : i + 4, i % 2);
    // Powered down: each bank takes only its own writes
    for (i = 0; i < 6; i = i + 1) begin
      pg = i < 3 ? 8 : 12;
      v = $random(seed);
      wrm(pg, 2 + 2 * i, v, pg / 12);
      rdc(8, 2 + 2 * i, 0);
      rdc(12, 2 + 2 * i, 1);
    end
    dcb_host_inst.wr16(13, 2, 16'h8000);
    mem[mk(13, 2, 1)] = 8'h80;
    mem[mk(13, 3, 1)] = 0;
    rdc(13, 2, 1);
    rdc(13, 3, 1);
    // Running without buffering locks the coefficients
    dac_right_pwr_i = 1'b1;
    dcb_host_inst.wr(8, 4, 8'h5a);
    rdz(8, 4);
    dac_right_pwr_i = 1'b0;
    rdc(8, 4, 0);
    // Buffered while running: writes go to the idle bank, then swap
    dcb_host_inst.wr(8, 1, 8'h04);
    dac_left_pwr_i = 1'b1;
    dcb_host_inst.rd(8, 1, d);
    chk(d, 16'h0004);
    wrm(8, 6, 8'h3c, 1);
    rdc(12, 6, 1);
    dcb_host_inst.wr(8, 1, 8'h05);
    st(0, 0);
    dcb_host_inst.rd(8, 1, d);
    chk(d, 16'h0006);
    wrm(12, 8, 8'hc3, 0);
    dac_left_pwr_i = 1'b0;
    rdc(8, 8, 0);
    rdc(12, 8, 1);
    rdc(8, 6, 0);
    end_sim;
  end
endmodule
bind dcb_filter_top dcb_filter_top_props dcb_filter_top_props_inst (.*);
